// ### pkg/dmc_pkg.sv
package dmc_pkg;

    // register map, byte addresses on the control port
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_SRC   = 8'h04;
    localparam logic [7:0] OFF_DST   = 8'h08;
    localparam logic [7:0] OFF_FC    = 8'h0c;
    localparam logic [7:0] OFF_CNT   = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_ENA   = 8'h18;

    // control word field positions
    localparam int CTL_GO_BIT   = 0;
    localparam int CTL_RST_BIT  = 1;
    localparam int CTL_MODE_LSB = 2;
    localparam int CTL_MODE_W   = 11;

    // event flag bit positions, shared by the flag and enable registers
    localparam int FLG_DONE = 0;
    localparam int FLG_WERR = 1;
    localparam int FLG_RERR = 2;
    localparam int FLG_NBUF = 3;
    localparam int FLG_BRK  = 4;
    localparam int FLG_AUX  = 5;
    localparam logic [7:0] FLG_IMPL = 8'h3f;

    // reset values
    localparam logic [7:0]  FC_RST  = 8'h00;
    localparam logic [7:0]  FLG_RST = 8'h00;
    localparam logic [7:0]  ENA_RST = 8'h00;
    localparam logic [31:0] PTR_RST = 32'h0000_0000;

    // port width codes
    localparam logic [1:0] WID_LONG = 2'h0;
    localparam logic [1:0] WID_BYTE = 2'h1;
    localparam logic [1:0] WID_WORD = 2'h2;

    // request generation codes
    localparam logic [1:0] REQ_INT_LIM = 2'h0;
    localparam logic [1:0] REQ_INT_MAX = 2'h1;
    localparam logic [1:0] REQ_EXT_LVL = 2'h2;
    localparam logic [1:0] REQ_EXT_EDG = 2'h3;

    // holding buffer depth in bytes
    localparam int HOLD_BYTES = 7;

    typedef struct packed {
        logic       descriptor_mode_enable;
        logic [1:0] source_port_width;
        logic [1:0] destination_port_width;
        logic       source_advance_enable;
        logic       destination_advance_enable;
        logic [1:0] request_source_select;
        logic       periph_on_source;
        logic       single_address;
    } dmc_mode_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [2:0]  size;
        logic [31:0] wdata;
        logic [3:0]  space_code;
    } dmc_mbus_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } dmc_state_t;

endpackage

// ### hdl/dmc_channel.sv
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - go starts internal; external waits for go
// - clearing go halts, state kept, resumable
// - go clears itself when transfer completes
// - go reads one until operand finishes
// - source pointer addresses reads, optional advance
// - source advance 1/2/4 by width, wraps
// - destination pointer addresses writes, optional advance
// - destination advance 1/2/4 by width, wraps
// - space code register, nibble per phase
// - byte count drops per operand, zero=4G
// - event flags sticky, write one clears
// - aux done on interrupting descriptor buffer
// - breakpoint during transfer sets flag
// - out of buffers in descriptor mode
// - read/write bus error flags, abort, no done
// - done on normal end, never on error
// - enable register gates event interrupt
// - hidden buffer packs and unpacks operands
// - request/acknowledge handshake, ignored when internal
// - end line driven on exhaust, input terminates
// - request source select encoding
// - software reset aborts, clears flags, mode
module dmc_channel (
    // clock and reset
    input  wire logic               mclk_i,
    input  wire logic               resetn_i,
    // register port
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [31:0]        reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [31:0]        reg_rdata_o,
    // system bus master
    output dmc_pkg::dmc_mbus_t      mbus_o,
    input  wire logic               mbus_ack_i,
    input  wire logic               mbus_err_i,
    input  wire logic [31:0]        mbus_rdata_i,
    // peripheral handshake
    input  wire logic               peripheral_request_line_n_i,
    output logic                    peripheral_ack_line_n_o,
    input  wire logic               transfer_end_line_n_i,
    output logic                    transfer_end_line_n_o,
    output logic                    transfer_end_line_oe_n_o,
    // descriptor controller and debug
    input  wire logic               breakpoint_i,
    input  wire logic               desc_irq_req_i,
    input  wire logic               desc_last_i,
    input  wire logic               desc_none_valid_i,
    output logic                    event_irq_o
);

    dmc_pkg::dmc_state_t st_q;
    dmc_pkg::dmc_mode_t  mode_q;
    dmc_pkg::dmc_mbus_t  mbus_q;
    logic [31:0] src_q, dst_q, cnt_q;
    logic [7:0]  fc_q, flags_q, ena_q, set_vec;
    logic [55:0] hold_q;
    logic [2:0]  fill_q, rs, ws, src_step, dst_step;
    logic        go_q, stop_q, reload_wait_q, end_pend_q, req_prev_q, edge_pend_q;
    logic        dack_n_q, end_drv_n_q, irq_q;
    logic [32:0] rem;
    logic        wr_ctrl, srst, wr_src, wr_dst, wr_cnt, cyc_done, cyc_ok;
    logic        want_write, req_ok, launch, halt_now, end_in, term, cnt_zero;
    logic        buf_next;
    // largest aligned step a pointer may take for its port width
    function automatic logic [2:0] step_of(input logic [1:0] wid, input logic [1:0] lo);
        if (wid == dmc_pkg::WID_LONG) begin
            return lo[0] ? 3'h1 : (lo[1] ? 3'h2 : 3'h4);
        end
        return (wid == dmc_pkg::WID_WORD && !lo[0]) ? 3'h2 : 3'h1;
    endfunction
    // shrink a step to what is left, never an illegal three-byte cycle
    function automatic logic [2:0] fit(input logic [2:0] s, input logic [32:0] lim);
        logic [2:0] m;
        m = (lim < {30'h0, s}) ? lim[2:0] : s;
        return (m == 3'h3) ? 3'h2 : m;
    endfunction
    // register port decode; software reset acts in the very cycle of the write
    assign wr_ctrl = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_CTRL);
    assign srst    = wr_ctrl && reg_wdata_i[dmc_pkg::CTL_RST_BIT];
    assign wr_src  = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_SRC);
    assign wr_dst  = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_DST);
    assign wr_cnt  = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_CNT);
    // transfer arithmetic; a count of zero stands for the full 4G
    assign rem      = (cnt_q == 32'h0) ? 33'h1_0000_0000 : {1'b0, cnt_q};
    assign src_step = step_of(mode_q.source_port_width, src_q[1:0]);
    assign dst_step = step_of(mode_q.destination_port_width, dst_q[1:0]);
    assign rs = mode_q.single_address
              ? fit(mode_q.periph_on_source ? src_step : dst_step, rem)
              : fit(src_step, rem - {30'h0, fill_q});
    assign ws = mode_q.single_address ? rs : fit(dst_step, {30'h0, fill_q});
    assign want_write = (fill_q != 3'h0) && ((fill_q >= dst_step) ||
                        ({30'h0, fill_q} == rem));
    assign cyc_done = (st_q != dmc_pkg::ST_IDLE) && (mbus_ack_i || mbus_err_i);
    assign cyc_ok   = cyc_done && !mbus_err_i;
    assign cnt_zero = (rem == {30'h0, ws});
    // request gating: internal modes never look at the request line
    always_comb begin
        case (mode_q.request_source_select)
            dmc_pkg::REQ_INT_LIM: req_ok = 1'b1;
            dmc_pkg::REQ_INT_MAX: req_ok = 1'b1;
            dmc_pkg::REQ_EXT_LVL: req_ok = !peripheral_request_line_n_i;
            dmc_pkg::REQ_EXT_EDG: req_ok = edge_pend_q;
            default:              req_ok = 1'b0;
        endcase
    end
    // end line as input, ignored while this end pulls it itself
    assign end_in = !transfer_end_line_n_i && transfer_end_line_oe_n_o;
    assign halt_now = stop_q && (fill_q == 3'h0);
    assign launch = go_q && !halt_now && !reload_wait_q && !end_pend_q &&
                    (st_q == dmc_pkg::ST_IDLE) &&
                    ((fill_q != 3'h0) || req_ok);
    // buffer finished on a descriptor that is not last: stay running, await reload
    assign buf_next = mode_q.descriptor_mode_enable && !desc_last_i;
    assign term = (cyc_done && mbus_err_i) ||
                  (end_pend_q && (st_q == dmc_pkg::ST_IDLE) && go_q) ||
                  (cyc_ok && (st_q == dmc_pkg::ST_WRITE) && (end_pend_q || end_in)) ||
                  (cyc_ok && (st_q == dmc_pkg::ST_WRITE) && cnt_zero && !buf_next);
    // events raised this cycle
    always_comb begin
        set_vec = 8'h00;
        set_vec[dmc_pkg::FLG_RERR] = cyc_done && mbus_err_i && !mbus_q.we;
        set_vec[dmc_pkg::FLG_WERR] = cyc_done && mbus_err_i && mbus_q.we;
        set_vec[dmc_pkg::FLG_DONE] = term && !(cyc_done && mbus_err_i);
        set_vec[dmc_pkg::FLG_AUX]  = cyc_ok && (st_q == dmc_pkg::ST_WRITE) && cnt_zero &&
                                     buf_next && desc_irq_req_i && !end_pend_q;
        set_vec[dmc_pkg::FLG_BRK]  = breakpoint_i && go_q;
        set_vec[dmc_pkg::FLG_NBUF] = desc_none_valid_i && mode_q.descriptor_mode_enable;
    end
    // go bit and pending stop; stop lands only on an operand boundary
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || srst) begin
            go_q   <= 1'b0;
            stop_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata_i[dmc_pkg::CTL_GO_BIT]) begin
            go_q   <= 1'b1;
            stop_q <= 1'b0;
        end else if (wr_ctrl && go_q) begin
            stop_q <= 1'b1;
        end else if (term) begin
            go_q   <= 1'b0;
            stop_q <= 1'b0;
        end else if (halt_now && (st_q == dmc_pkg::ST_IDLE)) begin
            go_q   <= 1'b0;
            stop_q <= 1'b0;
        end
    end
    // mode register, cleared by both resets
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || srst) begin
            mode_q <= '0;
        end else if (wr_ctrl) begin
            mode_q <= reg_wdata_i[dmc_pkg::CTL_MODE_LSB +: dmc_pkg::CTL_MODE_W];
        end
    end
    // sequencer and bus master; a software reset drops the cycle at once
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || srst) begin
            st_q      <= dmc_pkg::ST_IDLE;
            mbus_q    <= '0;
            dack_n_q    <= 1'b1;
            end_drv_n_q <= 1'b1;
        end else if (cyc_done || term) begin
            st_q      <= dmc_pkg::ST_IDLE;
            mbus_q    <= '0;
            dack_n_q    <= 1'b1;
            end_drv_n_q <= 1'b1;
        end else if (launch) begin
            mbus_q.req <= 1'b1;
            if (mode_q.single_address ? !mode_q.periph_on_source : want_write) begin
                st_q              <= dmc_pkg::ST_WRITE;
                mbus_q.we         <= 1'b1;
                mbus_q.addr       <= dst_q;
                mbus_q.size       <= ws;
                mbus_q.wdata      <= 32'(hold_q >> (8 * (32'(fill_q) - 32'(ws))))
                                     & ~(32'hffff_ffff << (8 * 32'(ws)));
                mbus_q.space_code <= fc_q[7:4];
                dack_n_q          <= !(mode_q.single_address || !mode_q.periph_on_source);
                end_drv_n_q       <= !cnt_zero;
            end else begin
                st_q              <= mode_q.single_address ? dmc_pkg::ST_WRITE
                                                           : dmc_pkg::ST_READ;
                mbus_q.we         <= 1'b0;
                mbus_q.addr       <= src_q;
                mbus_q.size       <= rs;
                mbus_q.wdata      <= 32'h0;
                mbus_q.space_code <= fc_q[3:0];
                dack_n_q          <= !(mode_q.single_address || mode_q.periph_on_source);
                end_drv_n_q       <= !(mode_q.single_address && cnt_zero);
            end
        end
    end
    // request edge capture and end-line latch
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || srst) begin
            req_prev_q  <= 1'b1;
            edge_pend_q <= 1'b0;
            end_pend_q  <= 1'b0;
        end else begin
            req_prev_q <= peripheral_request_line_n_i;
            if (launch && (fill_q == 3'h0)) begin
                edge_pend_q <= 1'b0;
            end else if (req_prev_q && !peripheral_request_line_n_i && go_q) begin
                edge_pend_q <= 1'b1;
            end
            if (term) begin
                end_pend_q <= 1'b0;
            end else if (end_in && go_q &&
                         (!mode_q.request_source_select[1] || !dack_n_q)) begin
                end_pend_q <= 1'b1;
            end
        end
    end
    // pointers, count and holding buffer; software writes win over hardware
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            src_q  <= dmc_pkg::PTR_RST;
            dst_q  <= dmc_pkg::PTR_RST;
            cnt_q  <= dmc_pkg::PTR_RST;
            hold_q <= 56'h0;
            fill_q <= 3'h0;
            reload_wait_q <= 1'b0;
        end else begin
            if (wr_src) begin
                src_q <= reg_wdata_i;
            end else if (cyc_ok && !mbus_q.we && mode_q.source_advance_enable) begin
                src_q <= src_q + 32'(mbus_q.size);
            end
            if (wr_dst) begin
                dst_q <= reg_wdata_i;
            end else if (cyc_ok && mbus_q.we && mode_q.destination_advance_enable) begin
                dst_q <= dst_q + 32'(mbus_q.size);
            end
            if (wr_cnt) begin
                cnt_q <= reg_wdata_i;
            end else if (cyc_ok && (st_q == dmc_pkg::ST_WRITE)) begin
                cnt_q <= cnt_q - 32'(mbus_q.size);
            end
            if (wr_cnt || srst) begin
                reload_wait_q <= 1'b0;
            end else if (set_vec[dmc_pkg::FLG_AUX] || (cyc_ok && cnt_zero && buf_next &&
                         (st_q == dmc_pkg::ST_WRITE))) begin
                reload_wait_q <= 1'b1;
            end
            if (srst || term) begin
                fill_q <= 3'h0;
            end else if (cyc_ok && (st_q == dmc_pkg::ST_READ)) begin
                hold_q <= (hold_q << (8 * 32'(mbus_q.size))) |
                          56'(mbus_rdata_i & ~(32'hffff_ffff << (8 * 32'(mbus_q.size))));
                fill_q <= fill_q + mbus_q.size;
            end else if (cyc_ok && !mode_q.single_address) begin
                fill_q <= fill_q - mbus_q.size;
            end
        end
    end
    // plain registers: space codes and enables
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            fc_q  <= dmc_pkg::FC_RST;
            ena_q <= dmc_pkg::ENA_RST;
        end else begin
            if (reg_wr_i && (reg_addr_i == dmc_pkg::OFF_FC)) begin
                fc_q <= reg_wdata_i[7:0];
            end
            if (reg_wr_i && (reg_addr_i == dmc_pkg::OFF_ENA)) begin
                ena_q <= reg_wdata_i[7:0] & dmc_pkg::FLG_IMPL;
            end
        end
    end
    // event flags: a new event beats a write-one clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || srst) begin
            flags_q <= dmc_pkg::FLG_RST;
        end else if (reg_wr_i && (reg_addr_i == dmc_pkg::OFF_FLAGS)) begin
            flags_q <= (flags_q & ~reg_wdata_i[7:0]) | set_vec;
        end else begin
            flags_q <= flags_q | set_vec;
        end
    end
    // interrupt request, from a flop
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & ena_q);
        end
    end
    // read data stand one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                dmc_pkg::OFF_CTRL:  reg_rdata_o <= {19'h0, mode_q, 1'b0, go_q};
                dmc_pkg::OFF_SRC:   reg_rdata_o <= src_q;
                dmc_pkg::OFF_DST:   reg_rdata_o <= dst_q;
                dmc_pkg::OFF_FC:    reg_rdata_o <= {24'h0, fc_q};
                dmc_pkg::OFF_CNT:   reg_rdata_o <= cnt_q;
                dmc_pkg::OFF_FLAGS: reg_rdata_o <= {24'h0, flags_q};
                dmc_pkg::OFF_ENA:   reg_rdata_o <= {24'h0, ena_q};
                default:            reg_rdata_o <= 32'h0;
            endcase
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end
    // pins straight from flops; the open-drain end line only ever pulls low
    assign mbus_o                   = mbus_q;
    assign peripheral_ack_line_n_o  = dack_n_q;
    assign transfer_end_line_n_o    = 1'b0;
    assign transfer_end_line_oe_n_o = end_drv_n_q;
    assign event_irq_o              = irq_q;
    // checks
    sequence s_read_ok;
        cyc_ok && !mbus_q.we;
    endsequence
    a_go_start: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_ctrl && reg_wdata_i[0] && !srst |=> go_q)
        else $error("go bit not set by software write");
    a_go_auto: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        set_vec[0] && !wr_ctrl |=> !go_q)
        else $error("go bit still set after completion");
    a_go_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_ctrl && !reg_wdata_i[0] && !srst && go_q && fill_q != 3'h0 && !term |=> go_q)
        else $error("go bit dropped mid operand");
    a_src_step: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_read_ok ##0 (mode_q.source_advance_enable && !wr_src)
        |=> src_q == $past(src_q) + 32'($past(mbus_q.size)))
        else $error("source pointer advance wrong");
    a_dst_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        cyc_ok && mbus_q.we && !mode_q.destination_advance_enable && !wr_dst |=> $stable(dst_q))
        else $error("destination pointer moved");
    a_code_phase: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        $rose(mbus_q.req) && $stable(fc_q)
        |-> mbus_q.space_code == (mbus_q.we ? fc_q[7:4] : fc_q[3:0]))
        else $error("space code does not match phase");
    a_cnt_drop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        cyc_ok && st_q == dmc_pkg::ST_WRITE && !wr_cnt
        |=> cnt_q == $past(cnt_q) - 32'($past(mbus_q.size)))
        else $error("byte count not decremented");
    a_w1c_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == dmc_pkg::OFF_FLAGS && !srst
        |=> (flags_q & $past(reg_wdata_i[7:0] & ~set_vec)) == 8'h00)
        else $error("flag not cleared by write one");
    a_err_abort: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        cyc_done && mbus_err_i && !srst && !wr_ctrl ##1 1'b1 |-> flags_q[1] || flags_q[2])
        else $error("bus error not recorded");
    a_no_done_err: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        cyc_done && mbus_err_i |-> !set_vec[dmc_pkg::FLG_DONE])
        else $error("done raised on error");
    a_brk_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        breakpoint_i && go_q && !srst |=> flags_q[dmc_pkg::FLG_BRK])
        else $error("breakpoint flag missing");
    a_ack_access: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !peripheral_ack_line_n_o |-> mbus_q.req)
        else $error("acknowledge outside a bus cycle");

endmodule

`default_nettype wire

// ### tb/dmc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// memory slave plus peripheral; answers after wait_i cycles
module dmc_mem_model (
    // clock and bus
    input  wire logic               mclk_i,
    input  wire dmc_pkg::dmc_mbus_t mbus_i,
    input  wire logic [1:0]         wait_i,
    input  wire logic               err_i,
    output logic                    ack_o = 1'b0,
    output logic                    err_o = 1'b0,
    output logic      [31:0]        rdata_o = 32'h0,
    // peripheral handshake
    input  wire logic               ask_i,
    input  wire logic               pack_n_i,
    output logic                    preq_n_o,
    // seen by the bench
    output logic      [31:0]        waddr_o = 32'h0,
    output logic      [31:0]        wdata_o = 32'h0,
    output logic                    seen_o = 1'b0
);
    logic [1:0] cnt_q = 2'h0;
    logic       served_q = 1'b0;

    // one answer per cycle; data toggles outside ack so stale data never matches
    always_ff @(posedge mclk_i) begin
        ack_o   <= 1'b0;
        err_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        if (mbus_i.req && !ack_o && !err_o) begin
            if (cnt_q == wait_i) begin
                cnt_q   <= 2'h0;
                ack_o   <= !err_i;
                err_o   <= err_i;
                rdata_o <= ~mbus_i.addr;
                seen_o  <= !pack_n_i;
                if (mbus_i.we) begin
                    waddr_o <= mbus_i.addr;
                    wdata_o <= mbus_i.wdata;
                end
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // request held as a level until an acknowledged cycle serves it
    always_ff @(posedge mclk_i) begin
        served_q <= ask_i & (served_q | (ack_o & !pack_n_i));
    end
    assign preq_n_o = !(ask_i && !served_q);
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
// register reads are noted in a queue and compared by the monitor
module tb;
    typedef struct { string nm; logic [31:0] v; } dmc_exp_t;
    dmc_exp_t           exp_q[$];
    logic               mclk_i = 1'b0;
    logic               resetn_i = 1'b0;
    logic [7:0]         a = 8'h00;
    logic [31:0]        wd = 32'h0;
    logic               wr = 1'b0;
    logic               rd = 1'b0;
    logic               rd_q = 1'b0;
    logic [31:0]        rdata, brdata, waddr, wdata;
    dmc_pkg::dmc_mbus_t mbus;
    logic               ack, err, preq_n, pack_n, oe_n, drv, irq, seen;
    logic [1:0]         wt = 2'h0;
    logic               er = 1'b0;
    logic               ask = 1'b0;
    logic               brk = 1'b0;
    logic               dnv = 1'b0;
    logic [31:0]        seed = 32'd39;
    int                 error_cnt = 0;
    int                 tests_run = 0;

    dmc_channel dmc_channel_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(a),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .mbus_o(mbus),
        .mbus_ack_i(ack), .mbus_err_i(err), .mbus_rdata_i(brdata),
        .peripheral_request_line_n_i(preq_n), .peripheral_ack_line_n_o(pack_n),
        .transfer_end_line_n_i(oe_n | drv), .transfer_end_line_n_o(drv),
        .transfer_end_line_oe_n_o(oe_n), .breakpoint_i(brk), .desc_irq_req_i(1'b0),
        .desc_last_i(1'b0), .desc_none_valid_i(dnv), .event_irq_o(irq));
    dmc_mem_model dmc_mem_model_i (.mclk_i(mclk_i), .mbus_i(mbus), .wait_i(wt), .err_i(er),
        .ack_o(ack), .err_o(err), .rdata_o(brdata), .ask_i(ask), .pack_n_i(pack_n),
        .preq_n_o(preq_n), .waddr_o(waddr), .wdata_o(wdata), .seen_o(seen));

    // clock and watchdog, far beyond the hundred-odd cycles the tests need
    initial forever #50 mclk_i = ~mclk_i;
    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        stop_test();
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk_i);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] ad, input logic [31:0] e, input string nm);
        @(posedge mclk_i);
        a <= ad;
        rd <= 1'b1;
        exp_q.push_back('{nm, e});
        @(posedge mclk_i);
        rd <= 1'b0;
    endtask

    // bounded wait for the enabled event
    task automatic wait_irq();
        int n;
        n = 0;
        @(negedge mclk_i);
        while (irq !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        check("event_irq", 32'h1, {31'h0, irq});
    endtask

    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge mclk_i) rd_q <= rd;
    always @(negedge mclk_i) begin
        if (rd_q && exp_q.size() > 0) begin
            check(exp_q[0].nm, exp_q[0].v, rdata);
            void'(exp_q.pop_front());
        end
    end

    initial begin
        logic [31:0] s, d, c;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rreg(dmc_pkg::OFF_FC, 32'h0, "fc");
        rreg(dmc_pkg::OFF_FLAGS, 32'h0, "flags");
        rreg(dmc_pkg::OFF_ENA, 32'h0, "ena");
        rreg(8'h1c, 32'h0, "hole");
        s = rnd();
        wreg(dmc_pkg::OFF_FC, {24'h0, s[7:0] | 8'h88});
        rreg(dmc_pkg::OFF_FC, {24'h0, s[7:0] | 8'h88}, "fc");
        $display("test registers finished");
        // byte reads packed into one word write
        s = rnd() & 32'hffff_fffe;
        d = rnd() & 32'hffff_fffe;
        c = 32'h0000_06d0;
        wreg(dmc_pkg::OFF_SRC, s);
        wreg(dmc_pkg::OFF_DST, d);
        wreg(dmc_pkg::OFF_CNT, 32'h2);
        wreg(dmc_pkg::OFF_ENA, 32'h1);
        wreg(dmc_pkg::OFF_CTRL, c | 32'h1);
        wait_irq();
        rreg(dmc_pkg::OFF_CTRL, c, "ctrl");
        rreg(dmc_pkg::OFF_SRC, s + 32'h2, "src");
        rreg(dmc_pkg::OFF_DST, d + 32'h2, "dst");
        rreg(dmc_pkg::OFF_CNT, 32'h0, "cnt");
        rreg(dmc_pkg::OFF_FLAGS, 32'h1, "flags");
        check("waddr", d, waddr);
        check("wdata", {16'h0, ~s[7:0], ~(s[7:0] | 8'h01)}, wdata & 32'hffff);
        wreg(dmc_pkg::OFF_FLAGS, 32'h0);
        rreg(dmc_pkg::OFF_FLAGS, 32'h1, "flags");
        wreg(dmc_pkg::OFF_FLAGS, 32'h1);
        rreg(dmc_pkg::OFF_FLAGS, 32'h0, "flags");
        $display("test packing finished");
        // read error ends the run without done, then software reset
        er <= 1'b1;
        wreg(dmc_pkg::OFF_SRC, s & 32'hffff_fffc);
        wreg(dmc_pkg::OFF_CNT, 32'h8);
        wreg(dmc_pkg::OFF_ENA, 32'h4);
        wreg(dmc_pkg::OFF_CTRL, 32'h0000_00c1);
        wait_irq();
        er <= 1'b0;
        rreg(dmc_pkg::OFF_FLAGS, 32'h4, "flags");
        rreg(dmc_pkg::OFF_CTRL, 32'h0000_00c0, "ctrl");
        wreg(dmc_pkg::OFF_CTRL, 32'h2);
        rreg(dmc_pkg::OFF_FLAGS, 32'h0, "flags");
        rreg(dmc_pkg::OFF_CTRL, 32'h0, "ctrl");
        $display("test error finished");
        // external level request, single address, slow slave
        wt <= 2'h2;
        wreg(dmc_pkg::OFF_CNT, 32'h1);
        wreg(dmc_pkg::OFF_ENA, 32'h1);
        wreg(dmc_pkg::OFF_CTRL, 32'h0000_0525);
        brk <= 1'b1;
        @(posedge mclk_i);
        brk <= 1'b0;
        ask <= 1'b1;
        wait_irq();
        rreg(dmc_pkg::OFF_CNT, 32'h0, "cnt");
        rreg(dmc_pkg::OFF_FLAGS, 32'h11, "flags");
        check("ack_n", 32'h1, {31'h0, seen});
        // edge request, peripheral reads from memory, then no buffers left
        wreg(dmc_pkg::OFF_FLAGS, 32'hff);
        ask <= 1'b0;
        wreg(dmc_pkg::OFF_CNT, 32'h1);
        wreg(dmc_pkg::OFF_CTRL, 32'h0000_053d);
        ask <= 1'b1;
        wait_irq();
        rreg(dmc_pkg::OFF_FLAGS, 32'h1, "flags");
        wreg(dmc_pkg::OFF_CTRL, 32'h0000_1000);
        dnv <= 1'b1;
        rreg(dmc_pkg::OFF_FLAGS, 32'h9, "flags");
        $display("test request finished");
        repeat (3) @(posedge mclk_i);
        stop_test();
    end
endmodule
`default_nettype wire
